// [hw/xmi_top.sv]
/*
 * External data space interface: effective address generation, on-chip
 * data RAM, mapped USB buffer window and the off-chip memory port.
 * Assumes the core holds a move request until done, and the USB side
 * answers a four-phase req/ack handshake on the buffer port.
 */
`timescale 1ns/10ps
`default_nettype none
module xmi_top #(
   parameter bit RAM_IS_4K = 1'b1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Core move request
   input wire logic mov_valid,
   input wire xmi_pkg::xmi_move_t mov,
   output logic mov_busy,
   output logic mov_done,
   output logic [7:0] mov_rdata,
   // USB buffer RAM port
   output logic buf_req,
   output logic buf_we,
   output logic [9:0] buf_addr,
   output logic [7:0] buf_wdata,
   input wire logic buf_ack,
   input wire logic [7:0] buf_rdata,
   // Off-chip port pins
   output xmi_pkg::xmi_pins_t pins,
   input wire logic [7:0] p2_in
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_DECODE, ST_ONCHIP, ST_BUF_REQ, ST_BUF_REL,
      ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_TAIL
   } xmi_state_t;

   // RULE20 on-chip RAM size
   logic [7:0] ram [0:4095];
   logic [15:0] ram_mask;
   assign ram_mask = RAM_IS_4K ? xmi_pkg::RAM_MASK_4K : xmi_pkg::RAM_MASK_2K;

   logic [7:0] config_reg, page, dp_high, dp_low;
   logic [7:0] next_config_reg, next_page, next_dp_high, next_dp_low, next_sfr_rdata;

   // Register group
   always_comb begin
      next_config_reg = config_reg;
      next_page = page;
      next_dp_high = dp_high;
      next_dp_low = dp_low;
      if (sfr_wr) begin
         unique case (sfr_addr)
            xmi_pkg::SFR_CONFIG: next_config_reg = sfr_wdata & xmi_pkg::CONFIG_WMASK;
            // RULE15 page select
            xmi_pkg::SFR_PAGE: next_page = sfr_wdata;
            // RULE3 pointer bytes
            xmi_pkg::SFR_DP_HIGH: next_dp_high = sfr_wdata;
            xmi_pkg::SFR_DP_LOW: next_dp_low = sfr_wdata;
            default: ;
         endcase
      end
      unique case (sfr_addr)
         xmi_pkg::SFR_CONFIG: next_sfr_rdata = config_reg;
         xmi_pkg::SFR_PAGE: next_sfr_rdata = page;
         xmi_pkg::SFR_DP_HIGH: next_sfr_rdata = dp_high;
         xmi_pkg::SFR_DP_LOW: next_sfr_rdata = dp_low;
         default: next_sfr_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         config_reg <= xmi_pkg::CONFIG_RESET;
         page <= xmi_pkg::PAGE_RESET;
         dp_high <= xmi_pkg::DP_RESET;
         dp_low <= xmi_pkg::DP_RESET;
         sfr_rdata <= 8'h00;
      end else begin
         config_reg <= next_config_reg;
         page <= next_page;
         dp_high <= next_dp_high;
         dp_low <= next_dp_low;
         sfr_rdata <= next_sfr_rdata;
      end
   end

   logic buf_map_en, nonmux;
   xmi_pkg::xmi_mode_t mode;
   logic [1:0] latch_width;
   assign buf_map_en = config_reg[xmi_pkg::BIT_BUF_MAP];
   // RULE16 mux select
   assign nonmux = config_reg[xmi_pkg::BIT_NONMUX];
   assign mode = xmi_pkg::xmi_mode_t'(config_reg[xmi_pkg::MODE_LSB +: 2]);
   assign latch_width = config_reg[xmi_pkg::LATCH_LSB +: 2];

   // Move sequencer group
   xmi_state_t state, next_state;
   xmi_pkg::xmi_move_t req, next_req;
   logic [15:0] addr, next_addr;
   logic [1:0] cnt, next_cnt;
   logic drive_hi, next_drive_hi;
   logic next_mov_done;
   logic [7:0] next_mov_rdata;
   logic next_buf_req;
   logic ram_we;
   logic [15:0] eff;
   logic in_window, on_chip;
   xmi_pkg::xmi_pins_t next_pins;

   // RULE1 byte-indexed address
   // RULE2 pointer address
   assign eff = req.wide ? {dp_high, dp_low} : {page, req.index};
   assign in_window = (eff >= xmi_pkg::BUF_BASE) && (eff <= xmi_pkg::BUF_LAST);

   // RULE17 mode decode
   always_comb begin
      unique case (mode)
         xmi_pkg::MODE_INTERNAL: on_chip = 1'b1;
         xmi_pkg::MODE_SPLIT_NOBANK: on_chip = eff <= ram_mask;
         xmi_pkg::MODE_SPLIT_BANK: on_chip = eff <= ram_mask;
         xmi_pkg::MODE_EXTERNAL: on_chip = 1'b0;
      endcase
   end

   function automatic xmi_pkg::xmi_pins_t pins_for(input xmi_state_t st, input logic [15:0] a,
         input logic wr, input logic mux, input logic hi, input logic [7:0] wd);
      xmi_pkg::xmi_pins_t p;
      p = '{default: 8'hff};
      p.p4_claim = 8'h00;
      p.p3_claim = 8'h00;
      p.p2_claim = 8'h00;
      p.p1_claim = 8'h00;
      // RULE9 claim only in off-chip phases
      if (st inside {ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_TAIL}) begin
         // RULE12 strobe pins
         p.p1_claim[xmi_pkg::PIN_WR] = 1'b1;
         p.p1_claim[xmi_pkg::PIN_RD] = 1'b1;
         p.p1_oe_n[xmi_pkg::PIN_WR] = 1'b0;
         p.p1_oe_n[xmi_pkg::PIN_RD] = 1'b0;
         p.p1_out[xmi_pkg::PIN_WR] = !(st == ST_STROBE && wr);
         p.p1_out[xmi_pkg::PIN_RD] = !(st == ST_STROBE && !wr);
         if (mux) begin
            // RULE21 latch high while low address is out
            p.p1_claim[xmi_pkg::PIN_ALE] = 1'b1;
            p.p1_oe_n[xmi_pkg::PIN_ALE] = 1'b0;
            p.p1_out[xmi_pkg::PIN_ALE] = st == ST_ALE_HI;
         end
         // RULE13 port 4 high address
         // RULE23 upper byte left to the latches
         if (hi) begin
            p.p4_claim = 8'hff;
            p.p4_oe_n = 8'h00;
            p.p4_out = a[15:8];
         end
         if (!mux) begin
            p.p3_claim = 8'hff;
            p.p3_oe_n = 8'h00;
            p.p3_out = a[7:0];
         end
         p.p2_claim = 8'hff;
         if (mux && st == ST_ALE_HI) begin
            p.p2_oe_n = 8'h00;
            p.p2_out = a[7:0];
         end else if (wr) begin
            p.p2_oe_n = 8'h00;
            p.p2_out = wd;
         end
         // RULE10 read data pins stay released otherwise
      end
      // RULE11 no output-mode control leaves this block
      return p;
   endfunction : pins_for

   always_comb begin
      next_state = state;
      next_req = req;
      next_addr = addr;
      next_cnt = cnt;
      next_drive_hi = drive_hi;
      next_mov_done = 1'b0;
      next_mov_rdata = mov_rdata;
      next_buf_req = buf_req;
      ram_we = 1'b0;
      unique case (state)
         ST_IDLE: begin
            // RULE19 moves go to the external data space
            if (mov_valid) begin
               next_req = mov;
               next_state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            next_cnt = 2'h0;
            next_drive_hi = req.wide || mode == xmi_pkg::MODE_SPLIT_BANK;
            // RULE5 window hides ordinary memory
            if (buf_map_en && in_window) begin
               // RULE4 buffer window
               next_addr = eff - xmi_pkg::BUF_BASE;
               next_buf_req = 1'b1;
               next_state = ST_BUF_REQ;
            end else if (on_chip) begin
               // RULE22 wrap on the RAM size
               next_addr = eff & ram_mask;
               next_state = ST_ONCHIP;
            end else begin
               next_addr = eff;
               next_state = nonmux ? ST_STROBE : ST_ALE_HI;
            end
         end
         ST_ONCHIP: begin
            ram_we = req.write;
            next_mov_rdata = ram[addr[11:0]];
            next_mov_done = 1'b1;
            next_state = ST_IDLE;
         end
         // RULE7 extra handshake cycles
         // RULE25 stall until the USB side answers
         ST_BUF_REQ: begin
            if (buf_ack) begin
               next_buf_req = 1'b0;
               next_mov_rdata = buf_rdata;
               next_state = ST_BUF_REL;
            end
         end
         ST_BUF_REL: begin
            if (!buf_ack) begin
               next_mov_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         // RULE18 latch widths
         ST_ALE_HI: begin
            next_cnt = cnt + 2'h1;
            if (cnt == latch_width) begin
               next_cnt = 2'h0;
               next_state = ST_ALE_LO;
            end
         end
         ST_ALE_LO: begin
            next_cnt = cnt + 2'h1;
            if (cnt == latch_width) begin
               next_cnt = 2'h0;
               next_state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            next_cnt = cnt + 2'h1;
            if (next_cnt == xmi_pkg::STROBE_CYCLES) begin
               next_cnt = 2'h0;
               if (!req.write) begin
                  next_mov_rdata = p2_in;
               end
               next_state = ST_TAIL;
            end
         end
         // RULE24 fixed overhead cycles
         ST_TAIL: begin
            next_cnt = cnt + 2'h1;
            if (next_cnt == xmi_pkg::TAIL_CYCLES) begin
               next_cnt = 2'h0;
               next_mov_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
      endcase
      next_pins = pins_for(next_state, next_addr, next_req.write, !nonmux, next_drive_hi,
         next_req.wdata);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         req <= '0;
         addr <= 16'h0000;
         cnt <= 2'h0;
         drive_hi <= 1'b0;
         mov_done <= 1'b0;
         mov_rdata <= 8'h00;
         buf_req <= 1'b0;
         pins <= pins_for(ST_IDLE, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      end else begin
         state <= next_state;
         req <= next_req;
         addr <= next_addr;
         cnt <= next_cnt;
         drive_hi <= next_drive_hi;
         mov_done <= next_mov_done;
         mov_rdata <= next_mov_rdata;
         buf_req <= next_buf_req;
         pins <= next_pins;
      end
   end

   // RAM holds no reset; contents are undefined until written
   always_ff @(posedge clock) begin
      if (ram_we) begin
         ram[addr[11:0]] <= req.wdata;
      end
   end

   // Busy covers the request cycle too so the core never double-issues
   assign mov_busy = (state != ST_IDLE) || mov_valid;
   assign buf_we = req.write;
   assign buf_addr = addr[9:0];
   assign buf_wdata = req.wdata;
endmodule : xmi_top
`default_nettype wire

// [hw/xmi_pkg.sv]
/*
 * Constants, types and field layout for the external data space interface:
 * register offsets on the special function register port, reset values,
 * memory modes, the core move request and the port pin bundle.
 * Assumes a single 100 MHz core clock and a core that stalls on busy.
 */
// Functional notes
// RULE1: Byte-indexed move address is page register high byte, index low byte.
// RULE2: Pointer move uses the whole 16-bit data pointer as address.
// RULE3: Data pointer is read and written as separate high and low bytes.
// RULE4: Buffer map enable places USB buffer RAM at 0x0400 to 0x07FF.
// RULE5: While mapped, normal memory in that window cannot be reached.
// RULE6: Software keeps USB clock at least twice the core clock.
// RULE7: Buffer RAM moves take more cycles than on-chip RAM moves.
// RULE8: Software must not touch live USB packet data through moves.
// RULE9: Port pins are claimed only while an off-chip move runs.
// RULE10: Pins acting as inputs have their drivers turned off.
// RULE11: Push-pull or open-drain mode is never touched by this block.
// RULE12: Write strobe on P1.7, read on P1.6, latch strobe on P1.3.
// RULE13: Off-chip address, data and control appear on ports 4, 3, 2, 1.
// RULE14: Software parks the port latches at logic 1 when idle.
// RULE15: Page register resets to zero and selects a 256-byte page.
// RULE16: Config bit 4 selects multiplexed (0) or separate pins (1).
// RULE17: Mode field: internal, split no bank, split with bank, external.
// RULE18: Latch pulse field sets latch high and low width to 1..4 cycles.
// RULE19: Moves target the external data space by default.
// RULE20: On-chip data RAM is 4k or 2k bytes by variant.
// RULE21: Latch strobe high with low address on shared pins, fall starts data.
// RULE22: Internal-only mode wraps addresses on the RAM size boundary.
// RULE23: Byte-indexed off-chip moves in modes 01 and 11 leave A15:8 undriven.
// RULE24: Off-chip move lasts its timing settings plus four cycles.
// RULE25: Buffer moves stall the core until the USB handshake completes.
package xmi_pkg;
   localparam logic [7:0] SFR_CONFIG = 8'h85;
   localparam logic [7:0] SFR_PAGE = 8'haa;
   localparam logic [7:0] SFR_DP_LOW = 8'h82;
   localparam logic [7:0] SFR_DP_HIGH = 8'h83;

   localparam logic [7:0] CONFIG_RESET = 8'h03;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] DP_RESET = 8'h00;
   // Bits 7 and 5 are unused and read as zero
   localparam logic [7:0] CONFIG_WMASK = 8'h5f;

   localparam int unsigned BIT_BUF_MAP = 6;
   localparam int unsigned BIT_NONMUX = 4;
   localparam int unsigned MODE_LSB = 2;
   localparam int unsigned LATCH_LSB = 0;

   localparam logic [15:0] BUF_BASE = 16'h0400;
   localparam logic [15:0] BUF_LAST = 16'h07ff;
   localparam logic [15:0] RAM_MASK_4K = 16'h0fff;
   localparam logic [15:0] RAM_MASK_2K = 16'h07ff;

   localparam logic [1:0] STROBE_CYCLES = 2'h1;
   // One decode cycle plus these tail cycles make the fixed four
   localparam logic [1:0] TAIL_CYCLES = 2'h3;

   localparam int unsigned PIN_WR = 7;
   localparam int unsigned PIN_RD = 6;
   localparam int unsigned PIN_ALE = 3;

   typedef enum logic [1:0] {
      MODE_INTERNAL,
      MODE_SPLIT_NOBANK,
      MODE_SPLIT_BANK,
      MODE_EXTERNAL
   } xmi_mode_t;

   typedef struct packed {
      logic wide;
      logic write;
      logic [7:0] index;
      logic [7:0] wdata;
   } xmi_move_t;

   typedef struct packed {
      logic [7:0] p4_out;
      logic [7:0] p4_oe_n;
      logic [7:0] p4_claim;
      logic [7:0] p3_out;
      logic [7:0] p3_oe_n;
      logic [7:0] p3_claim;
      logic [7:0] p2_out;
      logic [7:0] p2_oe_n;
      logic [7:0] p2_claim;
      logic [7:0] p1_out;
      logic [7:0] p1_oe_n;
      logic [7:0] p1_claim;
   } xmi_pins_t;
endpackage : xmi_pkg

// [bench/xmi_top_monitor.sv]
/* Port checker for xmi_top.
   Assumes it is bound to the top module. */
`timescale 1ns/10ps
`default_nettype none
module xmi_top_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Watched ports
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_rdata,
   input wire logic mov_busy,
   input wire logic mov_done,
   input wire logic buf_req,
   input wire logic [9:0] buf_addr,
   input wire logic buf_ack,
   input wire xmi_pkg::xmi_pins_t pins
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   done_pulse_a: assert property (mov_done |=> !mov_done)
      else $error("done held too long");
   pins_idle_a: assert property (!mov_busy |->
      (pins.p1_claim | pins.p2_claim | pins.p3_claim | pins.p4_claim) == 8'h00)
      else $error("pins claimed while idle");
   rd_float_a: assert property (pins.p1_claim[6] && !pins.p1_out[6] |->
      pins.p2_oe_n == 8'hff)
      else $error("data driven during read");
   wr_drive_a: assert property (pins.p1_claim[7] && !pins.p1_out[7] |->
      pins.p2_oe_n == 8'h00 && pins.p2_claim == 8'hff)
      else $error("data not driven during write");
   strobe_excl_a: assert property (pins.p1_claim[7:6] == 2'b11 |->
      pins.p1_out[7:6] != 2'b00)
      else $error("both strobes low");
   ale_first_a: assert property (pins.p1_claim[3] && $fell(pins.p1_out[3]) |->
      pins.p1_out[7:6] == 2'b11)
      else $error("strobe before latch fall");
   buf_hold_a: assert property (buf_req && !buf_ack |=> buf_req && $stable(buf_addr))
      else $error("buffer request dropped");
   buf_done_a: assert property ($fell(buf_ack) |-> ##[0:2] mov_done)
      else $error("no done after buffer ack");
   cfg_bits_a: assert property (sfr_addr == xmi_pkg::SFR_CONFIG |=>
      sfr_rdata[7] == 1'b0 && sfr_rdata[5] == 1'b0)
      else $error("unused config bits set");
   cover property (mov_done);
   cover property ($rose(buf_ack));
   cover property (pins.p1_claim[3] && $fell(pins.p1_out[3]));
endmodule : xmi_top_monitor
bind xmi_top xmi_top_monitor i_mon (.clock, .rst_n, .sfr_addr, .sfr_rdata, .mov_busy,
   .mov_done, .buf_req, .buf_addr, .buf_ack, .pins);
`default_nettype wire

// [bench/xmi_far_side.sv]
/* Far side model: USB buffer RAM and an off-chip byte memory.
   Assumes the pin bundle of xmi_top. */
`timescale 1ns/10ps
`default_nettype none
module xmi_far_side (
   // Clock, reset, answer speed
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] ack_delay,
   // Buffer port
   input wire logic buf_req,
   input wire logic buf_we,
   input wire logic [9:0] buf_addr,
   input wire logic [7:0] buf_wdata,
   output logic buf_ack,
   output logic [7:0] buf_rdata,
   // Off-chip pins
   input wire xmi_pkg::xmi_pins_t pins,
   output logic [7:0] p2_in
);
   logic [7:0] bram [1024];
   logic [7:0] xmem [65536];
   logic [7:0] low_latch = 8'h00;
   logic [7:0] last_rd = 8'h00;
   logic [3:0] wait_cnt;
   logic [15:0] xaddr;
   logic rd_on;
   // parked latches high
   // Software parks the port latches at ones, so unclaimed high address pins read high; unclaimed low pins give low_latch
   localparam logic [7:0] PARKED = 8'hff;
   assign xaddr = {pins.p4_claim[0] ? pins.p4_out : PARKED,
      pins.p3_claim[0] ? pins.p3_out : low_latch};
   assign rd_on = pins.p1_claim[6] && !pins.p1_out[6];
   // Released bus shows inverse of last byte
   assign p2_in = rd_on ? xmem[xaddr] : ~last_rd;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         buf_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (buf_req && !buf_ack) begin
         wait_cnt <= wait_cnt + 4'h1;
         if (wait_cnt >= ack_delay) begin
            buf_ack <= 1'b1;
            buf_rdata <= bram[buf_addr];
            if (buf_we) bram[buf_addr] <= buf_wdata;
         end
      end else if (buf_ack && !buf_req) begin
         buf_ack <= 1'b0;
         wait_cnt <= 4'h0;
         buf_rdata <= ~buf_rdata;
      end
   end
   always_ff @(posedge clock) begin
      if (pins.p1_claim[3] && pins.p1_out[3]) low_latch <= pins.p2_out;
      if (pins.p1_claim[7] && !pins.p1_out[7]) xmem[xaddr] <= pins.p2_out;
      if (rd_on) last_rd <= p2_in;
   end
endmodule : xmi_far_side
`default_nettype wire

// [bench/xmi_top_test.sv]
/* Self-checking bench for xmi_top.
   Assumes the far side model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module xmi_top_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic mov_valid = 1'b0;
   xmi_pkg::xmi_move_t mov = '0;
   logic [3:0] ack_delay = 4'h0;
   logic [7:0] sfr_rdata, mov_rdata, buf_wdata, buf_rdata, p2_in, d0, d1;
   logic mov_busy, mov_done, buf_req, buf_we, buf_ack;
   logic [9:0] buf_addr;
   xmi_pkg::xmi_pins_t pins;
   logic [8:0] notes [$];
   logic [8:0] note;
   int n_mismatch = 0;
   int checked = 0;
   int lat;
   always #5 clock = ~clock;
   xmi_top i_dut (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .mov_valid,
      .mov, .mov_busy, .mov_done, .mov_rdata, .buf_req, .buf_we, .buf_addr, .buf_wdata,
      .buf_ack, .buf_rdata, .pins, .p2_in);
   xmi_far_side i_far (.clock, .rst_n, .ack_delay, .buf_req, .buf_we, .buf_addr,
      .buf_wdata, .buf_ack, .buf_rdata, .pins, .p2_in);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("mismatches %0d, compares %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : put
   task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      sfr_addr <= a;
      repeat (2) @(posedge clock);
      check(16'(sfr_rdata), 16'(exp));
   endtask : reg_is
   // Sets pointer or page, then runs one move and returns its edge count
   task automatic move(input logic w, input logic wr, input logic [15:0] a,
         input logic [7:0] d, input logic [7:0] exp, output int n);
      if (w) begin
         put(xmi_pkg::SFR_DP_HIGH, a[15:8]);
         put(xmi_pkg::SFR_DP_LOW, a[7:0]);
      end else put(xmi_pkg::SFR_PAGE, a[15:8]);
      notes.push_back({!wr, exp});
      @(posedge clock);
      mov_valid <= 1'b1;
      mov <= '{w, wr, a[7:0], d};
      for (n = 1; n < 60; n++) begin
         @(posedge clock);
         #1;
         if (mov_done === 1'b1) break;
      end
      mov_valid <= 1'b0;
      if (n == 60) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : move
   always @(posedge clock) begin
      if (mov_done === 1'b1) begin
         if (notes.size() == 0) begin
            n_mismatch++;
            $display("ERROR %0t: move ended with no expected result", $time);
         end
         else begin
            note = notes.pop_front();
            if (note[8]) check(16'(mov_rdata), 16'(note[7:0]));
         end
      end
   end
   initial begin
      void'($urandom(86));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      reg_is(xmi_pkg::SFR_CONFIG, 8'h03);
      reg_is(xmi_pkg::SFR_PAGE, 8'h00);
      reg_is(8'h40, 8'h00);
      put(xmi_pkg::SFR_CONFIG, 8'hff);
      reg_is(xmi_pkg::SFR_CONFIG, 8'h5f);
      put(xmi_pkg::SFR_CONFIG, 8'h00);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      move(1'b1, 1'b1, 16'h0123, d0, 8'h00, lat);
      check(16'(lat), 16'd3);
      reg_is(xmi_pkg::SFR_DP_HIGH, 8'h01);
      move(1'b0, 1'b0, 16'h0123, 8'h00, d0, lat);
      move(1'b1, 1'b0, 16'h1123, 8'h00, d0, lat);
      move(1'b1, 1'b1, 16'h0456, d0, 8'h00, lat);
      put(xmi_pkg::SFR_CONFIG, 8'h40);
      ack_delay <= 4'h5;
      move(1'b1, 1'b1, 16'h0456, d1, 8'h00, lat);
      check(16'(lat > 4), 16'd1);
      move(1'b0, 1'b0, 16'h0456, 8'h00, d1, lat);
      put(xmi_pkg::SFR_CONFIG, 8'h00);
      move(1'b1, 1'b0, 16'h0456, 8'h00, d0, lat);
      put(xmi_pkg::SFR_CONFIG, 8'h1c);
      move(1'b1, 1'b1, 16'h1234, d1, 8'h00, lat);
      check(16'(lat), 16'd6);
      put(xmi_pkg::SFR_CONFIG, 8'h18);
      move(1'b0, 1'b0, 16'h1234, 8'h00, d1, lat);
      // Byte-indexed write leaves the high address to the parked latches
      put(xmi_pkg::SFR_CONFIG, 8'h1c);
      move(1'b0, 1'b1, 16'h1277, d1, 8'h00, lat);
      move(1'b1, 1'b0, 16'hff77, 8'h00, d1, lat);
      for (int k = 0; k < 4; k++) begin
         put(xmi_pkg::SFR_CONFIG, 8'h0c | 8'(k));
         d0 = 8'($urandom);
         move(1'b1, 1'b1, 16'h2000 + 16'(k), d0, 8'h00, lat);
         check(16'(lat), 16'(8 + 2 * k));
         move(1'b1, 1'b0, 16'h2000 + 16'(k), 8'h00, d0, lat);
      end
      put(xmi_pkg::SFR_CONFIG, 8'h14);
      move(1'b1, 1'b0, 16'h2003, 8'h00, d0, lat);
      repeat (3) @(posedge clock);
      check(16'(notes.size()), 16'd0);
      wrap_up();
   end
endmodule : xmi_top_test
`default_nettype wire
